/* rtl/but_pkg.sv */
// constants shared by the basic up-count timer
package but_pkg;
	localparam int DATA_W = 16;
	localparam int OFS_W = 8;
	localparam logic [OFS_W-1:0] OFS_CONTROL_ONE = 8'h00;
	localparam logic [OFS_W-1:0] OFS_CONTROL_TWO = 8'h04;
	localparam logic [OFS_W-1:0] OFS_INT_ENABLE = 8'h0c;
	localparam logic [OFS_W-1:0] OFS_STATUS = 8'h10;
	localparam logic [OFS_W-1:0] OFS_EVENT_GEN = 8'h14;
	localparam logic [OFS_W-1:0] OFS_COUNTER = 8'h24;
	localparam logic [OFS_W-1:0] OFS_PRESCALE = 8'h28;
	localparam logic [OFS_W-1:0] OFS_RELOAD = 8'h2c;
	localparam int BIT_COUNT_ENABLE = 0;
	localparam int BIT_UPDATE_DISABLE = 1;
	localparam int BIT_SOURCE_SEL = 2;
	localparam int BIT_RELOAD_PRELOAD = 7;
	localparam int MOS_LSB = 4;
	localparam int MOS_W = 3;
	localparam int BIT_IRQ_ENABLE = 0;
	localparam int BIT_DMA_ENABLE = 8;
	localparam int BIT_UPDATE_FLAG = 0;
	localparam int BIT_SW_UPDATE = 0;
	localparam logic [MOS_W-1:0] MOS_RESET = 3'h0;
	localparam logic [MOS_W-1:0] MOS_ENABLE = 3'h1;
	localparam logic [MOS_W-1:0] MOS_UPDATE = 3'h2;
	localparam logic [DATA_W-1:0] RST_COUNTER = 16'h0000;
	localparam logic [DATA_W-1:0] RST_PRESCALE = 16'h0000;
	localparam logic [DATA_W-1:0] RST_RELOAD = 16'h0000;
	localparam logic [MOS_W-1:0] RST_MOS = 3'h0;
endpackage : but_pkg

/* rtl/but_prescaler.sv */
// prescaler: divides the kernel clock by divisor plus one
`timescale 1ns/1ns
module but_prescaler #(
	parameter int W = 16
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_run,
	input wire logic i_restart,
	input wire logic [W-1:0] i_divisor,
	output logic o_tick
);
	typedef struct packed {
		logic [W-1:0] phase;
	} but_presc_state_t;

	but_presc_state_t st_r;
	but_presc_state_t st_nxt;

	initial begin
		if (W < 1 || W > 16) begin
			$error("prescaler width must be 1 to 16");
		end
	end

	// only the kernel clock feeds the divider
	assign o_tick = i_run && (st_r.phase == i_divisor);

	always_comb begin
		st_nxt = st_r;
		if (i_restart) begin
			st_nxt.phase = '0;
		end else if (o_tick) begin
			st_nxt.phase = '0;
		end else if (i_run) begin
			st_nxt.phase = st_r.phase + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	a_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
		o_tick && !i_restart && i_divisor != '0 && i_run |=> !o_tick)
		else $error("prescaler ticked twice in a row with divisor above zero");
endmodule : but_prescaler

/* rtl/but_timer.sv */
// basic up-count timer with buffered prescaler and reload
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
module but_timer #(
	parameter int ADDR_W = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [but_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [but_pkg::DATA_W-1:0] o_rdata,
	output logic o_irq,
	output logic o_dma_req,
	output logic o_trigger_output
);
	import but_pkg::*;

	typedef struct packed {
		logic count_enable_bit;
		logic update_disable_bit;
		logic update_request_source_sel;
		logic reload_preload_enable;
		logic [MOS_W-1:0] master_output_select;
		logic irq_enable;
		logic dma_enable;
		logic update_flag;
		logic [DATA_W-1:0] counter_value;
		logic [DATA_W-1:0] prescale_value;
		logic [DATA_W-1:0] prescale_active;
		logic [DATA_W-1:0] reload_value;
		logic [DATA_W-1:0] reload_active;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic dma_req;
		logic trigger_output;
	} but_state_t;

	localparam but_state_t RST_STATE = '{
		count_enable_bit: 1'b0,
		update_disable_bit: 1'b0,
		update_request_source_sel: 1'b0,
		reload_preload_enable: 1'b0,
		master_output_select: RST_MOS,
		irq_enable: 1'b0,
		dma_enable: 1'b0,
		update_flag: 1'b0,
		counter_value: RST_COUNTER,
		prescale_value: RST_PRESCALE,
		prescale_active: RST_PRESCALE,
		reload_value: RST_RELOAD,
		reload_active: RST_RELOAD,
		rdata: '0,
		irq: 1'b0,
		dma_req: 1'b0,
		trigger_output: 1'b0
	};

	localparam logic [ADDR_W-1:0] A_CONTROL_ONE = ADDR_W'(OFS_CONTROL_ONE);
	localparam logic [ADDR_W-1:0] A_CONTROL_TWO = ADDR_W'(OFS_CONTROL_TWO);
	localparam logic [ADDR_W-1:0] A_INT_ENABLE = ADDR_W'(OFS_INT_ENABLE);
	localparam logic [ADDR_W-1:0] A_STATUS = ADDR_W'(OFS_STATUS);
	localparam logic [ADDR_W-1:0] A_EVENT_GEN = ADDR_W'(OFS_EVENT_GEN);
	localparam logic [ADDR_W-1:0] A_COUNTER = ADDR_W'(OFS_COUNTER);
	localparam logic [ADDR_W-1:0] A_PRESCALE = ADDR_W'(OFS_PRESCALE);
	localparam logic [ADDR_W-1:0] A_RELOAD = ADDR_W'(OFS_RELOAD);

	initial begin
		if (ADDR_W < 6 || ADDR_W > OFS_W) begin
			$error("address width must be 6 to 8");
		end
	end

	but_state_t st_r;
	but_state_t st_nxt;
	logic tick;
	logic wr_counter;
	logic software_update_request;
	logic overrun;
	logic update_event;
	logic update_passed;
	logic [DATA_W-1:0] rd_word;

	assign wr_counter = i_wr && (i_addr == A_COUNTER);
	// writing one to the event bit asks for an update
	assign software_update_request = i_wr && (i_addr == A_EVENT_GEN)
		&& i_wdata[BIT_SW_UPDATE];
	assign overrun = tick && (st_r.counter_value == st_r.reload_active);
	assign update_event = (overrun || software_update_request)
		&& !st_r.update_disable_bit;
	// source filter ahead of flag, interrupt and dma
	assign update_passed = update_event
		&& (overrun || !st_r.update_request_source_sel);

	but_prescaler #(
		.W(DATA_W)
	) u_prescaler (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_run(st_r.count_enable_bit),
		.i_restart(update_event),
		.i_divisor(st_r.prescale_active),
		.o_tick(tick)
	);

	// read mux
	always_comb begin
		rd_word = '0;
		if (i_addr == A_CONTROL_ONE) begin
			rd_word[BIT_COUNT_ENABLE] = st_r.count_enable_bit;
			rd_word[BIT_UPDATE_DISABLE] = st_r.update_disable_bit;
			rd_word[BIT_SOURCE_SEL] = st_r.update_request_source_sel;
			rd_word[BIT_RELOAD_PRELOAD] = st_r.reload_preload_enable;
		end else if (i_addr == A_CONTROL_TWO) begin
			rd_word[MOS_LSB +: MOS_W] = st_r.master_output_select;
		end else if (i_addr == A_INT_ENABLE) begin
			rd_word[BIT_IRQ_ENABLE] = st_r.irq_enable;
			rd_word[BIT_DMA_ENABLE] = st_r.dma_enable;
		end else if (i_addr == A_STATUS) begin
			rd_word[BIT_UPDATE_FLAG] = st_r.update_flag;
		end else if (i_addr == A_COUNTER) begin
			rd_word = st_r.counter_value;
		end else if (i_addr == A_PRESCALE) begin
			rd_word = st_r.prescale_value;
		end else if (i_addr == A_RELOAD) begin
			rd_word = st_r.reload_value;
		end
	end

	always_comb begin
		st_nxt = st_r;
		st_nxt.rdata = i_rd ? rd_word : '0;
		// counting and wrap
		if (overrun || update_event) begin
			st_nxt.counter_value = '0;
		end else if (tick) begin
			st_nxt.counter_value = st_r.counter_value + 1'b1;
		end
		// transfer of pending values on update
		if (update_event) begin
			st_nxt.prescale_active = st_r.prescale_value;
			st_nxt.reload_active = st_r.reload_value;
		end
		if (i_wr) begin
			if (i_addr == A_CONTROL_ONE) begin
				st_nxt.count_enable_bit = i_wdata[BIT_COUNT_ENABLE];
				st_nxt.update_disable_bit = i_wdata[BIT_UPDATE_DISABLE];
				st_nxt.update_request_source_sel = i_wdata[BIT_SOURCE_SEL];
				st_nxt.reload_preload_enable = i_wdata[BIT_RELOAD_PRELOAD];
			end else if (i_addr == A_CONTROL_TWO) begin
				st_nxt.master_output_select = i_wdata[MOS_LSB +: MOS_W];
			end else if (i_addr == A_INT_ENABLE) begin
				st_nxt.irq_enable = i_wdata[BIT_IRQ_ENABLE];
				st_nxt.dma_enable = i_wdata[BIT_DMA_ENABLE];
			end else if (i_addr == A_STATUS) begin
				if (i_wdata[BIT_UPDATE_FLAG]) begin
					st_nxt.update_flag = 1'b0;
				end
			end else if (i_addr == A_COUNTER) begin
				st_nxt.counter_value = i_wdata;
			end else if (i_addr == A_PRESCALE) begin
				st_nxt.prescale_value = i_wdata;
			end else if (i_addr == A_RELOAD) begin
				st_nxt.reload_value = i_wdata;
				if (!st_r.reload_preload_enable) begin
					st_nxt.reload_active = i_wdata;
				end
			end
		end
		// set wins over a clear in the same cycle
		if (update_passed) begin
			st_nxt.update_flag = 1'b1;
		end
		st_nxt.irq = st_nxt.update_flag && st_nxt.irq_enable;
		st_nxt.dma_req = update_passed && st_r.dma_enable;
		// trigger routing toward the converter
		case (st_r.master_output_select)
			MOS_RESET: st_nxt.trigger_output = software_update_request;
			MOS_ENABLE: st_nxt.trigger_output = st_r.count_enable_bit;
			MOS_UPDATE: st_nxt.trigger_output = update_event;
			default: st_nxt.trigger_output = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			st_r <= RST_STATE;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rdata = st_r.rdata;
	assign o_irq = st_r.irq;
	assign o_dma_req = st_r.dma_req;
	assign o_trigger_output = st_r.trigger_output;

	// checks
	a_count_wrap: assert property (@(posedge i_clk) disable iff (i_rst)
		overrun && !wr_counter |=> st_r.counter_value == '0)
		else $error("counter did not restart from zero after reload match");

	a_count_step: assert property (@(posedge i_clk) disable iff (i_rst)
		tick && !overrun && !update_event && !wr_counter
		|=> st_r.counter_value == $past(st_r.counter_value) + 16'h0001)
		else $error("counter did not advance by one on a tick");

	a_count_hold: assert property (@(posedge i_clk) disable iff (i_rst)
		!st_r.count_enable_bit && !software_update_request && !wr_counter
		|=> $stable(st_r.counter_value))
		else $error("counter moved while disabled");

	a_update_block: assert property (@(posedge i_clk) disable iff (i_rst)
		st_r.update_disable_bit && !(i_wr && i_addr == A_PRESCALE)
		|=> $stable(st_r.prescale_active))
		else $error("prescale moved while updates disabled");

	a_presc_load: assert property (@(posedge i_clk) disable iff (i_rst)
		update_event |=> st_r.prescale_active == $past(st_r.prescale_value))
		else $error("prescale not transferred on update");

	a_presc_buffer: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == A_PRESCALE && !update_event
		|=> st_r.prescale_active == $past(st_r.prescale_active))
		else $error("prescale write took effect before update");

	a_reload_direct: assert property (@(posedge i_clk) disable iff (i_rst)
		i_wr && i_addr == A_RELOAD && !st_r.reload_preload_enable
		|=> st_r.reload_active == $past(i_wdata))
		else $error("reload write without preload not immediate");

	a_source_filter: assert property (@(posedge i_clk) disable iff (i_rst)
		software_update_request && !overrun && st_r.update_request_source_sel
		|=> !o_dma_req)
		else $error("software update raised dma with source select set");

	a_dma_request: assert property (@(posedge i_clk) disable iff (i_rst)
		update_passed && st_r.dma_enable |=> o_dma_req ##1 !o_dma_req || $past(update_passed))
		else $error("dma request missing after update");

	a_flag_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
		update_passed |=> st_r.update_flag ##1 (st_r.update_flag || $past(i_wr)))
		else $error("update flag not set or lost without clear");

	a_trigger_enable: assert property (@(posedge i_clk) disable iff (i_rst)
		st_r.master_output_select == MOS_ENABLE
		|=> o_trigger_output == $past(st_r.count_enable_bit))
		else $error("trigger output does not follow count enable");

	a_trigger_update: assert property (@(posedge i_clk) disable iff (i_rst)
		st_r.master_output_select == MOS_UPDATE && update_event |=> o_trigger_output)
		else $error("trigger output missed an update");
endmodule : but_timer

/* tb/but_testbench.sv */
// self-checking testbench for the basic up-count timer
`timescale 1ns/1ns
module testbench;
	import but_pkg::*;
	localparam logic [DATA_W-1:0] EN = 16'h0001 << BIT_COUNT_ENABLE;
	localparam logic [DATA_W-1:0] UD = 16'h0001 << BIT_UPDATE_DISABLE;
	localparam logic [DATA_W-1:0] SEL = 16'h0001 << BIT_SOURCE_SEL;
	localparam logic [DATA_W-1:0] PRE = 16'h0001 << BIT_RELOAD_PRELOAD;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [7:0] i_addr = 8'h00;
	logic [DATA_W-1:0] i_wdata = 16'h0000;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [DATA_W-1:0] o_rdata;
	logic o_irq;
	logic o_dma_req;
	logic o_trigger_output;
	int error_cnt = 0;
	int n_tests = 0;
	int cyc = 0;
	int m_psc, m_arr, n_psc, n_arr, t0, t1;
	int n_dma = 0;
	int n_trg = 0;
	int dma_cyc = 0;
	int trg_cyc = 0;
	logic [DATA_W-1:0] exp_q [$];
	bit g;
	logic [DATA_W-1:0] rv, rv2, w;
	logic [OFS_W-1:0] ofs [9] = '{OFS_CONTROL_ONE, OFS_CONTROL_TWO, OFS_INT_ENABLE, OFS_STATUS,
		OFS_EVENT_GEN, OFS_COUNTER, OFS_PRESCALE, OFS_RELOAD, 8'h08};
	logic [DATA_W-1:0] msk [9] = '{16'h0086, 16'h0070, 16'h0101, 16'h0000, 16'h0000,
		16'hffff, 16'hffff, 16'hffff, 16'h0000};
	but_timer #(.ADDR_W(8)) dut_u (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_addr(i_addr),
		.i_wdata(i_wdata),
		.i_wr(i_wr),
		.i_rd(i_rd),
		.o_rdata(o_rdata),
		.o_irq(o_irq),
		.o_dma_req(o_dma_req),
		.o_trigger_output(o_trigger_output)
	);
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
	end
	// pulses stand one cycle: count them mid-cycle where they are settled
	always @(negedge i_clk) begin
		if (o_dma_req === 1'b1) begin
			n_dma++;
			dma_cyc = cyc;
		end
		if (o_trigger_output === 1'b1) begin
			n_trg++;
			trg_cyc = cyc;
		end
	end
	task automatic report_and_stop;
		if (error_cnt == 0 && n_tests > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : report_and_stop
	task automatic chk_val(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: register %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_pin(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: output %b expected %b", $time, got, exp);
		end
	endtask : chk_pin
	task automatic chk_gap(input int got, input int exp);
		n_tests++;
		if (got != exp) begin
			error_cnt++;
			$display("wrong value at %0t: period %0d expected %0d", $time, got, exp);
		end
	endtask : chk_gap
	task automatic wr(input logic [OFS_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [OFS_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask : rd
	task automatic step;
		@(posedge i_clk);
		#1;
	endtask : step
	task automatic wait_pulse(input int s, input int lim, output bit f, output int t);
		int c0;
		c0 = (s == 0) ? n_dma : n_trg;
		f = 1'b0;
		t = 0;
		for (int k = 0; k < lim && !f; k++) begin
			step();
			if (((s == 0) ? n_dma : n_trg) != c0) begin
				f = 1'b1;
				t = (s == 0) ? dma_cyc : trg_cyc;
			end
		end
	endtask : wait_pulse
	task automatic need(input int s, output int t);
		bit f;
		wait_pulse(s, 3000, f, t);
		if (!f) begin
			error_cnt++;
			$display("wrong value at %0t: pulse never came", $time);
			report_and_stop();
		end
	endtask : need
	initial begin
		rv = $urandom(32'h0c7cea73);
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		step();
		chk_pin(o_irq | o_dma_req | o_trigger_output, 1'b0);
		for (int i = 0; i < 9; i++) begin
			rd(ofs[i], rv);
			chk_val(rv, 16'h0000);
		end
		for (int i = 0; i < 9; i++) begin
			w = 16'($urandom()) & ~16'h0001;
			wr(ofs[i], w);
			exp_q.push_back(w & msk[i]);
		end
		for (int i = 0; i < 9; i++) begin
			rd(ofs[i], rv);
			chk_val(rv, exp_q.pop_front());
		end
		wr(OFS_INT_ENABLE, 16'h0101);
		wr(OFS_CONTROL_TWO, 16'(MOS_UPDATE) << MOS_LSB);
		wr(OFS_CONTROL_ONE, EN | PRE);
		for (int j = 0; j < 3; j++) begin
			m_psc = $urandom() % 4;
			m_arr = 4 + $urandom() % 12;
			n_psc = $urandom() % 4;
			n_arr = 4 + $urandom() % 12;
			wr(OFS_PRESCALE, 16'(m_psc));
			wr(OFS_RELOAD, 16'(m_arr));
			wr(OFS_EVENT_GEN, 16'h0001);
			need(0, t0);
			need(0, t1);
			chk_gap(t1 - t0, (m_psc + 1) * (m_arr + 1));
			chk_gap(trg_cyc, t1);
			chk_pin(o_irq, 1'b1);
			wr(OFS_PRESCALE, 16'(n_psc));
			wr(OFS_RELOAD, 16'(n_arr));
			need(0, t0);
			chk_gap(t0 - t1, (m_psc + 1) * (m_arr + 1));
			need(0, t1);
			chk_gap(t1 - t0, (n_psc + 1) * (n_arr + 1));
		end
		wr(OFS_CONTROL_ONE, EN);
		need(0, t0);
		wr(OFS_RELOAD, 16'(n_arr + 10));
		need(0, t1);
		chk_gap(t1 - t0, (n_psc + 1) * (n_arr + 11));
		wr(OFS_CONTROL_ONE, EN | UD);
		wr(OFS_STATUS, 16'h0001);
		wait_pulse(0, 3 * (n_psc + 1) * (n_arr + 11), g, t0);
		chk_pin(g, 1'b0);
		rd(OFS_STATUS, rv);
		chk_val(rv, 16'h0000);
		wr(OFS_CONTROL_ONE, SEL);
		wr(OFS_EVENT_GEN, 16'h0001);
		wait_pulse(0, 10, g, t0);
		chk_pin(g, 1'b0);
		rd(OFS_STATUS, rv);
		chk_val(rv, 16'h0000);
		wr(OFS_CONTROL_ONE, 16'h0000);
		wr(OFS_CONTROL_TWO, 16'(MOS_RESET) << MOS_LSB);
		wr(OFS_EVENT_GEN, 16'h0001);
		need(0, t0);
		rd(OFS_STATUS, rv);
		chk_val(rv, 16'h0001);
		wr(OFS_EVENT_GEN, 16'h0001);
		need(1, t0);
		chk_pin(o_irq, 1'b1);
		wr(OFS_INT_ENABLE, 16'h0100);
		step();
		chk_pin(o_irq, 1'b0);
		wr(OFS_INT_ENABLE, 16'h0001);
		step();
		chk_pin(o_irq, 1'b1);
		wr(OFS_STATUS, 16'h0001);
		step();
		chk_pin(o_irq, 1'b0);
		wr(OFS_CONTROL_TWO, 16'(MOS_ENABLE) << MOS_LSB);
		wr(OFS_CONTROL_ONE, EN);
		step();
		chk_pin(o_trigger_output, 1'b1);
		wr(OFS_CONTROL_ONE, 16'h0000);
		step();
		chk_pin(o_trigger_output, 1'b0);
		rd(OFS_COUNTER, rv);
		repeat (5) step();
		rd(OFS_COUNTER, rv2);
		chk_val(rv2, rv);
		wr(OFS_CONTROL_TWO, 16'h0030);
		wr(OFS_EVENT_GEN, 16'h0001);
		wait_pulse(1, 5, g, t0);
		chk_pin(g, 1'b0);
		report_and_stop();
	end
endmodule : testbench
